// *** rtcx_map.vh ***
// constants for the clock access port and its timebase
`ifndef RTCX_MAP_VH
`define RTCX_MAP_VH
// =============================================
// special function register addresses and reset values
`define RTCX_ADDR_INDEX      8'hAC
`define RTCX_ADDR_DATA       8'hAD
`define RTCX_INDEX_RESET     8'h10
`define RTCX_DATA_RESET      8'h00
// =============================================
// index register fields
`define RTCX_BIT_BUSY        7
`define RTCX_BIT_AUTO_READ   6
`define RTCX_BIT_UNUSED      5
`define RTCX_BIT_SHORT       4
`define RTCX_IDX_MSB         3
// =============================================
// access timing in system clocks
`define RTCX_CYC_NORMAL      3'h7
`define RTCX_CYC_SHORT       3'h6
// =============================================
// internal register addresses
`define RTCX_IA_CAP_LO       4'h0
`define RTCX_IA_CAP_HI       4'h3
`define RTCX_IA_CTRL         4'h4
`define RTCX_IA_OSC_CTRL     4'h5
`define RTCX_IA_OSC_CFG      4'h6
`define RTCX_IA_ALM_LO       4'h8
`define RTCX_IA_ALM_HI       4'hB
// =============================================
// internal register fields
`define RTCX_CTRL_POWER      7
`define RTCX_CTRL_MCD        6
`define RTCX_CTRL_FAIL       5
`define RTCX_OCTL_AGC        7
`define RTCX_OCTL_XSEL       6
`define RTCX_OCTL_BIAS       5
`define RTCX_OCTL_VALID      4
`define RTCX_OCTL_SLOW_ON    3
`define RTCX_OCFG_CAP_READY  6
`define RTCX_OCFG_CAP_MSB    3
// =============================================
// timebase source codes
`define RTCX_SRC_OFF         2'h0
`define RTCX_SRC_CRYSTAL     2'h1
`define RTCX_SRC_SELFOSC     2'h2
`define RTCX_SRC_LFO         2'h3
`endif

// *** rtcx_ireg.v ***
// internal clock register bank reached through the access port
`timescale 1ns/1ps
`include "rtcx_map.vh"
module rtcx_ireg (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       ce,
  input  wire       wr,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       osc_fail_flag,
  input  wire       clock_valid_flag,
  input  wire       load_cap_ready_flag,
  output reg  [7:0] rdata,
  output wire       osc_power_enable,
  output wire       missing_clk_enable,
  output wire       gain_control_enable,
  output wire       crystal_mode_select,
  output wire       bias_doubling,
  output wire       low_freq_osc_enable,
  output wire [3:0] load_cap_setting
);
  reg [7:0] mem_reg [0:15];
  integer   i;
  // =============================================
  // storage
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (ce && wr) begin
      mem_reg[addr] <= wdata;
    end
  end
  // =============================================
  // read with live hardware flags
  always @* begin
    rdata = mem_reg[addr];
    case (addr)
      `RTCX_IA_CTRL:     rdata[`RTCX_CTRL_FAIL] = osc_fail_flag;
      `RTCX_IA_OSC_CTRL: rdata[`RTCX_OCTL_VALID] = clock_valid_flag;
      `RTCX_IA_OSC_CFG:  rdata[`RTCX_OCFG_CAP_READY] = load_cap_ready_flag;
      default:           rdata = mem_reg[addr];
    endcase
  end
  assign osc_power_enable    = mem_reg[`RTCX_IA_CTRL][`RTCX_CTRL_POWER];
  assign missing_clk_enable  = mem_reg[`RTCX_IA_CTRL][`RTCX_CTRL_MCD];
  assign gain_control_enable = mem_reg[`RTCX_IA_OSC_CTRL][`RTCX_OCTL_AGC];
  assign crystal_mode_select = mem_reg[`RTCX_IA_OSC_CTRL][`RTCX_OCTL_XSEL];
  assign bias_doubling       = mem_reg[`RTCX_IA_OSC_CTRL][`RTCX_OCTL_BIAS];
  assign low_freq_osc_enable = mem_reg[`RTCX_IA_OSC_CTRL][`RTCX_OCTL_SLOW_ON];
  assign load_cap_setting    = mem_reg[`RTCX_IA_OSC_CFG][`RTCX_OCFG_CAP_MSB:0];
endmodule // rtcx_ireg

// *** rtcx_timebase.v ***
// timebase selection and tick counting for the clock
`timescale 1ns/1ps
`include "rtcx_map.vh"
module rtcx_timebase (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire        osc_tick,
  input  wire        lfo_tick,
  input  wire        osc_power_enable,
  input  wire        crystal_mode_select,
  input  wire        bias_doubling,
  input  wire        low_freq_osc_enable,
  output reg  [1:0]  src_sel_reg,
  output reg         crystal_pin_short_reg,
  output reg         self_osc_fast_reg,
  output reg  [31:0] timer_reg
);
  reg [1:0] src_sel_next;
  wire      tick;
  // =============================================
  // source choice
  always @* begin
    if (low_freq_osc_enable) begin
      src_sel_next = `RTCX_SRC_LFO;
    end else if (!osc_power_enable) begin
      src_sel_next = `RTCX_SRC_OFF;
    end else if (crystal_mode_select) begin
      src_sel_next = `RTCX_SRC_CRYSTAL;
    end else begin
      src_sel_next = `RTCX_SRC_SELFOSC;
    end
  end
  assign tick = (src_sel_reg == `RTCX_SRC_LFO) ? lfo_tick :
                (src_sel_reg == `RTCX_SRC_OFF) ? 1'b0 : osc_tick;
  // =============================================
  // registered selection and timer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_sel_reg           <= `RTCX_SRC_OFF;
      crystal_pin_short_reg <= 1'b0;
      self_osc_fast_reg     <= 1'b0;
      timer_reg             <= 32'h00000000;
    end else if (ce) begin
      src_sel_reg           <= src_sel_next;
      crystal_pin_short_reg <= (src_sel_next == `RTCX_SRC_SELFOSC);
      self_osc_fast_reg     <= bias_doubling;
      if (tick) begin
        if (src_sel_reg == `RTCX_SRC_LFO) begin
          timer_reg <= timer_reg + 32'h00000002;
        end else begin
          timer_reg <= timer_reg + 32'h00000001;
        end
      end
    end
  end
endmodule // rtcx_timebase

// *** rtcx_top.v ***
// indirect access port to the clock registers, with its timebase
`timescale 1ns/1ps
`include "rtcx_map.vh"
module rtcx_top (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        por_b,
  input  wire        ce,
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  input  wire        osc_tick,
  input  wire        lfo_tick,
  input  wire        osc_fail_flag,
  input  wire        clock_valid_flag,
  input  wire        load_cap_ready_flag,
  output reg  [7:0]  sfr_rdata,
  output wire        osc_power_enable,
  output wire        missing_clk_enable,
  output wire        gain_control_enable,
  output wire        crystal_mode_select,
  output wire        bias_doubling,
  output wire        low_freq_osc_enable,
  output wire [3:0]  load_cap_setting,
  output wire [1:0]  timebase_sel,
  output wire        crystal_pin_short,
  output wire        self_osc_fast,
  output wire [31:0] rtc_timer
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg  [1:0] state_reg;
  reg  [2:0] cnt_reg;
  reg        short_reg;
  reg        auto_read_reg;
  reg  [3:0] index_reg;
  reg  [7:0] rtc_data_window;
  reg        ireg_wr_reg;
  wire [7:0] ireg_rdata;
  wire       wr_index;
  wire       wr_data;
  wire       rd_data;
  wire       idle;
  wire       start_rd;
  wire       done;
  wire [7:0] rtc_index_control;

  // =============================================
  // decode helpers
  function auto_inc;
    input [3:0] a;
    begin
      auto_inc = (a <= `RTCX_IA_CAP_HI) ||
                 ((a >= `RTCX_IA_ALM_LO) && (a <= `RTCX_IA_ALM_HI));
    end
  endfunction

  function [2:0] access_len;
    input s;
    begin
      access_len = s ? `RTCX_CYC_SHORT : `RTCX_CYC_NORMAL;
    end
  endfunction

  assign wr_index = sfr_wr && (sfr_addr == `RTCX_ADDR_INDEX);
  assign wr_data  = sfr_wr && (sfr_addr == `RTCX_ADDR_DATA);
  assign rd_data  = sfr_rd && (sfr_addr == `RTCX_ADDR_DATA);
  assign idle     = (state_reg == ST_IDLE);
  assign start_rd = (wr_index && sfr_wdata[`RTCX_BIT_BUSY]) ||
                    (rd_data && auto_read_reg);
  assign done     = !idle && (cnt_reg == 3'h1);
  assign rtc_index_control = {!idle, auto_read_reg, 1'b0,
                              short_reg, index_reg};

  // =============================================
  // access sequencer, cleared by device reset
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 3'h0;
      short_reg   <= 1'b1;
      ireg_wr_reg <= 1'b0;
    end else if (ce) begin
      ireg_wr_reg <= 1'b0;
      if (wr_index) begin
        short_reg <= sfr_wdata[`RTCX_BIT_SHORT];
      end
      case (state_reg)
        ST_IDLE: begin
          if (wr_data) begin
            state_reg <= ST_WRITE;
            cnt_reg   <= access_len(short_reg);
          end else if (start_rd) begin
            state_reg <= ST_READ;
            cnt_reg   <= access_len(short_reg);
          end
        end
        ST_READ, ST_WRITE: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (done) begin
            ireg_wr_reg <= (state_reg == ST_WRITE);
            state_reg   <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // =============================================
  // index and data, kept over device reset
  always @(posedge mclk or negedge por_b) begin
    if (!por_b) begin
      auto_read_reg   <= 1'b0;
      index_reg       <= 4'h0;
      rtc_data_window <= `RTCX_DATA_RESET;
    end else if (ce) begin
      if (wr_index) begin
        auto_read_reg <= sfr_wdata[`RTCX_BIT_AUTO_READ];
        index_reg     <= sfr_wdata[`RTCX_IDX_MSB:0];
      end else if (ireg_wr_reg && auto_inc(index_reg)) begin
        index_reg <= index_reg + 4'h1;
      end else if (done && (state_reg == ST_READ) &&
                   auto_inc(index_reg)) begin
        index_reg <= index_reg + 4'h1;
      end
      if (wr_data && idle) begin
        rtc_data_window <= sfr_wdata;
      end else if (done && (state_reg == ST_READ)) begin
        rtc_data_window <= ireg_rdata;
      end
    end
  end

  // =============================================
  // register read port
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else if (ce) begin
      if (sfr_rd && (sfr_addr == `RTCX_ADDR_INDEX)) begin
        sfr_rdata <= rtc_index_control;
      end else if (rd_data) begin
        sfr_rdata <= rtc_data_window;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // =============================================
  // internal registers and timebase
  rtcx_ireg u_ireg (
    .mclk                (mclk),
    .rst_b               (rst_b),
    .ce                  (ce),
    .wr                  (ireg_wr_reg),
    .addr                (index_reg),
    .wdata               (rtc_data_window),
    .osc_fail_flag       (osc_fail_flag),
    .clock_valid_flag    (clock_valid_flag),
    .load_cap_ready_flag (load_cap_ready_flag),
    .rdata               (ireg_rdata),
    .osc_power_enable    (osc_power_enable),
    .missing_clk_enable  (missing_clk_enable),
    .gain_control_enable (gain_control_enable),
    .crystal_mode_select (crystal_mode_select),
    .bias_doubling       (bias_doubling),
    .low_freq_osc_enable (low_freq_osc_enable),
    .load_cap_setting    (load_cap_setting)
  );

  rtcx_timebase u_tb (
    .mclk                  (mclk),
    .rst_b                 (rst_b),
    .ce                    (ce),
    .osc_tick              (osc_tick),
    .lfo_tick              (lfo_tick),
    .osc_power_enable      (osc_power_enable),
    .crystal_mode_select   (crystal_mode_select),
    .bias_doubling         (bias_doubling),
    .low_freq_osc_enable   (low_freq_osc_enable),
    .src_sel_reg           (timebase_sel),
    .crystal_pin_short_reg (crystal_pin_short),
    .self_osc_fast_reg     (self_osc_fast),
    .timer_reg             (rtc_timer)
  );
endmodule // rtcx_top

// *** rtcx_top_checker.sv ***
// assertions on the ports of the clock access port
`timescale 1ns/1ps
module rtcx_top_checker (
  input wire        mclk,
  input wire        rst_b,
  input wire        ce,
  input wire [7:0]  sfr_addr,
  input wire        sfr_rd,
  input wire [7:0]  sfr_rdata,
  input wire        osc_tick,
  input wire        lfo_tick,
  input wire        bias_doubling,
  input wire        low_freq_osc_enable,
  input wire [1:0]  timebase_sel,
  input wire        crystal_pin_short,
  input wire        self_osc_fast,
  input wire [31:0] rtc_timer
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // =============================================
  // sequences
  sequence idx_rd;
    ce && sfr_rd && sfr_addr == 8'hAC;
  endsequence
  sequence odd_rd;
    ce && sfr_rd && sfr_addr != 8'hAC && sfr_addr != 8'hAD;
  endsequence
  sequence quiet;
    (!osc_tick && !lfo_tick)[*3];
  endsequence
  // =============================================
  // assertions
  a_unused_bit_zero: assert property (idx_rd |=> !sfr_rdata[5])
    else $error("index bit 5 read as one");
  a_idle_rdata_zero: assert property (
    ce && !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero without read");
  a_unmapped_zero: assert property (odd_rd |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_selfosc_short: assert property (
    (timebase_sel == 2'h2)[*3] |-> crystal_pin_short)
    else $error("crystal pins not shorted");
  a_lfo_bit_hold: assert property (
    (timebase_sel == 2'h3)[*3] |-> $stable(rtc_timer[0]))
    else $error("timer bit 0 moved under slow oscillator");
  a_no_tick_hold: assert property (quiet |=> $stable(rtc_timer))
    else $error("timer moved without tick");
  a_fast_bias: assert property (
    $stable(bias_doubling)[*3] |-> self_osc_fast == bias_doubling)
    else $error("fast hint differs from bias");
  a_lfo_select: assert property (
    low_freq_osc_enable[*3] |-> timebase_sel == 2'h3)
    else $error("slow oscillator not selected");
endmodule // rtcx_top_checker

bind rtcx_top rtcx_top_checker u_chk (
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .osc_tick(osc_tick), .lfo_tick(lfo_tick),
  .bias_doubling(bias_doubling), .low_freq_osc_enable(low_freq_osc_enable),
  .timebase_sel(timebase_sel), .crystal_pin_short(crystal_pin_short),
  .self_osc_fast(self_osc_fast), .rtc_timer(rtc_timer)
);

// *** rtcx_host.sv ***
// host model driving the special function register bus
`timescale 1ns/1ps
module rtcx_host (
  input  wire       mclk,
  input  wire [7:0] sfr_rdata,
  output reg  [7:0] sfr_addr,
  output reg        sfr_wr,
  output reg        sfr_rd,
  output reg  [7:0] sfr_wdata
);
  initial begin
    sfr_addr = 8'h53;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // =============================================
  // single read, data taken the cycle after
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge mclk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      sfr_addr <= ~a;
      #1 d = sfr_rdata;
    end
  endtask
  // =============================================
  // plain write, then count busy cycles on the index
  task access(input [7:0] a, input [7:0] v, output integer n);
    integer i;
    begin
      n = 0;
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= v;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
      sfr_wdata <= ~v;
      sfr_addr <= 8'hAC;
      sfr_rd <= 1'b1;
      for (i = 0; i < 12; i = i + 1) begin
        @(posedge mclk);
        #1 if (sfr_rdata[7]) n = n + 1;
      end
      sfr_rd <= 1'b0;
      sfr_addr <= 8'h53;
    end
  endtask
endmodule // rtcx_host

// *** rtcx_top_tb.sv ***
// self-checking bench for the clock access port
`timescale 1ns/1ps
module rtcx_top_tb;
  reg         mclk, rst_b, por_b, ce, osc_tick, lfo_tick;
  reg         osc_fail, clk_vld, ld_rdy;
  wire [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  wire        sfr_wr, sfr_rd, xsel, bias, slow_on, pshort, fast;
  wire        pwr, mcd, agc;
  wire [3:0]  lcap;
  wire [1:0]  tsel;
  wire [31:0] timer;
  reg  [7:0]  d;
  reg  [31:0] t0;
  integer     n, i, fails, n_tests, cyc;
  rtcx_host host (.mclk(mclk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
  rtcx_top dut (.mclk(mclk), .rst_b(rst_b), .por_b(por_b), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .osc_tick(osc_tick), .lfo_tick(lfo_tick),
    .osc_fail_flag(osc_fail), .clock_valid_flag(clk_vld),
    .load_cap_ready_flag(ld_rdy), .sfr_rdata(sfr_rdata),
    .osc_power_enable(pwr), .missing_clk_enable(mcd),
    .gain_control_enable(agc),
    .crystal_mode_select(xsel), .bias_doubling(bias),
    .low_freq_osc_enable(slow_on), .load_cap_setting(lcap),
    .timebase_sel(tsel), .crystal_pin_short(pshort),
    .self_osc_fast(fast), .rtc_timer(timer));
  // =============================================
  // tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task iw(input [3:0] a, input [7:0] v);
    begin
      host.access(8'hAC, {4'h1, a}, n);
      host.access(8'hAD, v, n);
    end
  endtask
  task ticks(input low_freq_oscillator, input integer k);
    begin
      t0 = timer;
      repeat (k) begin
        @(posedge mclk);
        osc_tick <= ~low_freq_oscillator;
        lfo_tick <= low_freq_oscillator;
        @(posedge mclk);
        osc_tick <= 1'b0;
        lfo_tick <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      #1;
    end
  endtask
  // =============================================
  // clock and timeout
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      conclude;
    end
  end
  // =============================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    por_b = 1'b0;
    ce = 1'b1;
    osc_tick = 1'b0;
    lfo_tick = 1'b0;
    osc_fail = 1'b0;
    clk_vld = 1'b0;
    ld_rdy = 1'b0;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    host.rd(8'hAC, d);
    chk(d, 8'h10);
    host.access(8'hAC, 8'hB6, n);
    chk(n, 6);
    host.rd(8'hAC, d);
    chk(d, 8'h16);
    host.access(8'hAC, 8'h26, n);
    host.access(8'hAD, 8'h0A, n);
    chk(n, 7);
    chk(lcap, 4'hA);
    host.access(8'hAC, 8'h86, n);
    chk(n, 7);
    host.rd(8'hAD, d);
    chk(d, 8'h0A);
    host.access(8'hAC, 8'h18, n);
    for (i = 1; i < 5; i = i + 1)
      host.access(8'hAD, 8'h11 * i, n);
    host.rd(8'hAC, d);
    chk(d, 8'h1C);
    host.access(8'hAC, 8'hD8, n);
    for (i = 1; i < 5; i = i + 1) begin
      host.rd(8'hAD, d);
      chk(d, 8'h11 * i);
      repeat (8) @(posedge mclk);
    end
    host.access(8'hAE, 8'hFF, n);
    host.rd(8'hAE, d);
    chk(d, 8'h00);
    host.rd(8'hAC, d);
    chk(d, 8'h5C);
    host.access(8'hAC, 8'h09, n);
    host.access(8'hAD, 8'h5A, n);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    host.rd(8'hAC, d);
    chk(d, 8'h1A);
    host.rd(8'hAD, d);
    chk(d, 8'h5A);
    iw(4'h4, 8'h80);
    iw(4'h5, 8'h08);
    chk({slow_on, tsel}, 3'h7);
    ticks(1'b1, 3);
    chk(timer - t0, 6);
    iw(4'h5, 8'h20);
    chk({tsel, pshort, fast}, 4'hB);
    ticks(1'b0, 3);
    chk(timer - t0, 3);
    iw(4'h5, 8'h40);
    chk({tsel, pshort, xsel}, 4'h5);
    ticks(1'b0, 2);
    chk(timer - t0, 2);
    iw(4'h4, 8'h00);
    chk(tsel, 2'h0);
    iw(4'h5, 8'h60);
    iw(4'h6, 8'h07);
    chk({agc, xsel, bias, lcap}, 7'h37);
    iw(4'h4, 8'h80);
    chk({pwr, tsel}, 3'h5);
    repeat (20) @(posedge mclk);
    clk_vld <= 1'b1;
    ld_rdy <= 1'b1;
    host.access(8'hAC, 8'h95, n);
    host.rd(8'hAD, d);
    chk(d, 8'h70);
    host.access(8'hAC, 8'h96, n);
    host.rd(8'hAD, d);
    chk(d, 8'h47);
    iw(4'h5, 8'hC0);
    iw(4'h4, 8'hC0);
    chk({agc, xsel, bias, pwr, mcd}, 5'h1B);
    iw(4'h5, 8'h40);
    chk({agc, bias, tsel}, 4'h1);
    @(posedge mclk);
    osc_fail <= 1'b1;
    host.access(8'hAC, 8'h94, n);
    host.rd(8'hAD, d);
    chk(d, 8'hE0);
    conclude;
  end
endmodule // rtcx_top_tb
